/* File: hw/tis_pkg.sv */
package tis_pkg;

   // ******************************
   // register map
   // ******************************
   localparam int unsigned TIS_ADDR_W = 12;
   localparam logic [11:0] TIS_OFF_ENABLE = 12'h018;
   localparam logic [11:0] TIS_OFF_RAW = 12'h01c;
   localparam logic [11:0] TIS_OFF_MASKED = 12'h020;
   localparam logic [11:0] TIS_OFF_CLEAR = 12'h024;

   // ******************************
   // field layout
   // ******************************
   localparam int unsigned TIS_NUM_SRC = 7;
   localparam logic [31:0] TIS_IMPL_MASK = 32'h0000_070f;
   localparam logic [31:0] TIS_RESET_VAL = 32'h0000_0000;
   localparam logic [31:0] TIS_RESERVED_READ = 32'h0000_0000;
   localparam logic [1:0] TIS_RESP_OKAY = 2'b00;
   localparam logic [1:0] TIS_RESP_SLVERR = 2'b10;

   // event index to register bit position
   function automatic int unsigned tis_bit_pos(input int unsigned idx);
      int unsigned pos;
      pos = (idx < 4) ? idx : idx + 4;
      return pos;
   endfunction

   // ******************************
   // state of the bus slave
   // ******************************
   typedef enum logic [0:0]
   {
      TIS_IDLE = 1'b0,
      TIS_RESP = 1'b1
   } tis_bus_type;

endpackage

/* File: hw/tis_status_bits.sv */
`timescale 1ns/1ps
module tis_status_bits
   import tis_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   tis_status_if.bits sif
);

   typedef struct packed
   {
      logic [6:0] raw;
   } tis_bits_state_type;

   tis_bits_state_type state;
   tis_bits_state_type next_state;

   always_comb
   begin
      next_state = state;
      for (int i = 0; i < TIS_NUM_SRC; i++)
      begin
         // set wins over a clear in the same cycle
         if (sif.event_pulse[i])
         begin
            next_state.raw[i] = 1'b1; // R4
         end
         else if (sif.clear_pulse[i])
         begin
            next_state.raw[i] = 1'b0; // R5
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         state <= '0; // R8
      end
      else
      begin
         state <= next_state;
      end
   end

   assign sif.raw = state.raw;
   assign sif.masked = state.raw & sif.enable; // R9 R10
endmodule

/* File: hw/tis_status_if.sv */
`timescale 1ns/1ps
interface tis_status_if;
   logic [6:0] event_pulse;
   logic [6:0] clear_pulse;
   logic [6:0] enable;
   logic [6:0] raw;
   logic [6:0] masked;

   modport ctrl
   (
      output event_pulse,
      output clear_pulse,
      output enable,
      input raw,
      input masked
   );

   modport bits
   (
      input event_pulse,
      input clear_pulse,
      input enable,
      output raw,
      output masked
   );
endinterface

/* File: hw/tis_timer_irq.sv */
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
// How it works
// R1: one enables a source, zero disables it
// R2: enables at bits 10:8 and 3:0
// R3: all enables reset to zero
// R4: raw bit sets on event regardless of enable
// R5: writing one to clear drops raw bit
// R6: raw timer b bits at 10:8
// R7: raw clock and timer a bits at 3:0
// R8: raw status read-only, resets to zero
// R9: masked bit needs enable and event
// R10: clear register one drops masked bit
// R11: masked layout matches raw layout
// R12: masked status read-only, resets to zero
// R13: reserved bits read zero, writes ignored
// R14: clear register is write-one-to-clear
// R15: interrupt high while any masked bit set
module tis_timer_irq
   import tis_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic a_timeout,
   input wire logic a_capture_match,
   input wire logic a_capture_event,
   input wire logic clock_event,
   input wire logic b_timeout,
   input wire logic b_capture_match,
   input wire logic b_capture_event,
   output logic irq,
   input wire logic [TIS_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [TIS_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // ******************************
   // state
   // ******************************
   typedef struct packed
   {
      logic aw_held;
      logic [TIS_ADDR_W-1:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      tis_bus_type wr_st;
      logic [1:0] bresp;
      tis_bus_type rd_st;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [6:0] enable;
      logic irq;
   } tis_state_type;

   tis_state_type state;
   tis_state_type next_state;
   tis_status_if sif();

   logic [6:0] events;
   logic [31:0] enable_word;
   logic [31:0] raw_word;
   logic [31:0] masked_word;

   assign events = {b_capture_event, b_capture_match, b_timeout, clock_event,
                    a_capture_event, a_capture_match, a_timeout};

   // ******************************
   // bit placement
   // ******************************
   always_comb
   begin
      enable_word = TIS_RESERVED_READ; // R13
      raw_word = TIS_RESERVED_READ;
      masked_word = TIS_RESERVED_READ;
      for (int i = 0; i < TIS_NUM_SRC; i++)
      begin
         enable_word[tis_bit_pos(i)] = state.enable[i]; // R2
         raw_word[tis_bit_pos(i)] = sif.raw[i]; // R6 R7
         masked_word[tis_bit_pos(i)] = sif.masked[i]; // R11
      end
   end

   tis_status_bits u_bits
   (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .sif(sif)
   );

   assign sif.event_pulse = events;
   assign sif.enable = state.enable;

   // ******************************
   // bus handshakes
   // ******************************
   assign s_axi_awready = !state.aw_held && (state.wr_st == TIS_IDLE);
   assign s_axi_wready = !state.w_held && (state.wr_st == TIS_IDLE);
   assign s_axi_arready = (state.rd_st == TIS_IDLE);
   assign s_axi_bvalid = (state.wr_st == TIS_RESP);
   assign s_axi_bresp = state.bresp;
   assign s_axi_rvalid = (state.rd_st == TIS_RESP);
   assign s_axi_rdata = state.rdata;
   assign s_axi_rresp = state.rresp;
   assign irq = state.irq;

   logic aw_now;
   logic w_now;
   logic [TIS_ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_go;
   logic [31:0] wr_mask;

   always_comb
   begin
      aw_now = s_axi_awvalid && s_axi_awready;
      w_now = s_axi_wvalid && s_axi_wready;
      wr_addr = state.aw_held ? state.aw_addr : s_axi_awaddr;
      wr_data = state.w_held ? state.w_data : s_axi_wdata;
      wr_strb = state.w_held ? state.w_strb : s_axi_wstrb;
      wr_go = (state.aw_held || aw_now) && (state.w_held || w_now);
      for (int b = 0; b < 4; b++)
      begin
         wr_mask[b*8 +: 8] = {8{wr_strb[b]}};
      end
   end

   // ******************************
   // next state
   // ******************************
   logic [31:0] clr_word;

   always_comb
   begin
      next_state = state;
      clr_word = '0;
      if (aw_now)
      begin
         next_state.aw_held = 1'b1;
         next_state.aw_addr = s_axi_awaddr;
      end
      if (w_now)
      begin
         next_state.w_held = 1'b1;
         next_state.w_data = s_axi_wdata;
         next_state.w_strb = s_axi_wstrb;
      end
      unique case (state.wr_st)
         TIS_IDLE:
         begin
            if (wr_go)
            begin
               next_state.aw_held = 1'b0;
               next_state.w_held = 1'b0;
               next_state.wr_st = TIS_RESP;
               next_state.bresp = TIS_RESP_OKAY;
               unique case (wr_addr)
                  TIS_OFF_ENABLE:
                  begin
                     for (int i = 0; i < TIS_NUM_SRC; i++)
                     begin
                        if (wr_mask[tis_bit_pos(i)])
                        begin
                           next_state.enable[i] = wr_data[tis_bit_pos(i)]; // R1
                        end
                     end
                  end
                  TIS_OFF_CLEAR:
                  begin
                     clr_word = wr_data & wr_mask & TIS_IMPL_MASK; // R14
                  end
                  TIS_OFF_RAW, TIS_OFF_MASKED:
                  begin
                     next_state.bresp = TIS_RESP_OKAY; // R8 R12
                  end
                  default:
                  begin
                     next_state.bresp = TIS_RESP_SLVERR;
                  end
               endcase
            end
         end
         TIS_RESP:
         begin
            if (s_axi_bready)
            begin
               next_state.wr_st = TIS_IDLE;
            end
         end
      endcase
      unique case (state.rd_st)
         TIS_IDLE:
         begin
            if (s_axi_arvalid)
            begin
               next_state.rd_st = TIS_RESP;
               next_state.rresp = TIS_RESP_OKAY;
               unique case (s_axi_araddr)
                  TIS_OFF_ENABLE: next_state.rdata = enable_word;
                  TIS_OFF_RAW: next_state.rdata = raw_word;
                  TIS_OFF_MASKED: next_state.rdata = masked_word;
                  TIS_OFF_CLEAR: next_state.rdata = TIS_RESERVED_READ;
                  default:
                  begin
                     next_state.rdata = TIS_RESERVED_READ;
                     next_state.rresp = TIS_RESP_SLVERR;
                  end
               endcase
            end
         end
         TIS_RESP:
         begin
            if (s_axi_rready)
            begin
               next_state.rd_st = TIS_IDLE;
            end
         end
      endcase
      next_state.irq = |(sif.masked); // R15
   end

   always_comb
   begin
      for (int i = 0; i < TIS_NUM_SRC; i++)
      begin
         sif.clear_pulse[i] = clr_word[tis_bit_pos(i)]; // R5 R10
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         state <= '0;
         state.enable <= TIS_RESET_VAL[6:0]; // R3
      end
      else
      begin
         state <= next_state;
      end
   end

endmodule

/* File: verification/tb.sv */
`timescale 1ns/1ps
module tb
   import tis_pkg::*;
;
   logic core_clk = 0;
   logic sys_rst = 1;
   logic [6:0] ev = 0;
   logic irq, awready, wready, bvalid, arready, rvalid;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [1:0] bresp, rresp;
   int num_errors = 0;
   int checks_done = 0;
   always #12.5 core_clk = ~core_clk;
   tis_timer_irq u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .a_timeout(ev[0]),
      .a_capture_match(ev[1]), .a_capture_event(ev[2]), .clock_event(ev[3]),
      .b_timeout(ev[4]), .b_capture_match(ev[5]), .b_capture_event(ev[6]), .irq(irq),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   // ******************************
   // bus and compare tasks
   // ******************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] er = TIS_RESP_OKAY);
      logic ta, tw, fin;
      logic [1:0] r;
      fin = 0;
      r = 2'b11;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      for (int n = 0; n < 50 && !fin; n++)
      begin
         @(negedge core_clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         fin = bvalid;
         r = bresp;
         @(posedge core_clk);
         if (ta) awvalid <= 0;
         if (tw) wvalid <= 0;
         if (fin) bready <= 0;
      end
      chk(32'(fin), 32'h0000_0001);
      chk(32'(r), 32'(er));
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ta, fin;
      logic [31:0] d;
      logic [1:0] r;
      fin = 0;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      for (int n = 0; n < 50 && !fin; n++)
      begin
         @(negedge core_clk);
         ta = arvalid && arready;
         fin = rvalid;
         d = rdata;
         r = rresp;
         @(posedge core_clk);
         if (ta) arvalid <= 0;
         if (fin) rready <= 0;
      end
      chk(d, e);
      chk(32'(r), 32'(er));
   endtask
   task automatic fire(input int i);
      @(posedge core_clk);
      ev <= 7'h01 << i;
      @(posedge core_clk);
      ev <= 7'h00;
   endtask
   function automatic logic [31:0] bit_of(input int i);
      return 32'h0000_0001 << ((i < 4) ? i : i + 4);
   endfunction
   // ******************************
   // scenarios
   // ******************************
   task automatic t_reset();
      chk(32'(irq), 32'h0000_0000);
      rchk(TIS_OFF_ENABLE, 32'h0000_0000, TIS_RESP_OKAY);
      rchk(TIS_OFF_RAW, 32'h0000_0000, TIS_RESP_OKAY);
      rchk(TIS_OFF_MASKED, 32'h0000_0000, TIS_RESP_OKAY);
      rchk(12'h030, 32'h0000_0000, TIS_RESP_SLVERR);
      wr(12'h030, 32'h0000_0000, TIS_RESP_SLVERR);
      rchk(TIS_OFF_ENABLE, 32'h0000_0000, TIS_RESP_OKAY);
      $display("test reset done");
   endtask
   task automatic t_raw();
      logic [31:0] acc;
      acc = 0;
      for (int i = 0; i < 7; i++)
      begin
         fire(i);
         acc |= bit_of(i);
         rchk(TIS_OFF_RAW, acc, TIS_RESP_OKAY);
      end
      rchk(TIS_OFF_MASKED, 32'h0000_0000, TIS_RESP_OKAY);
      chk(32'(irq), 32'h0000_0000);
      wr(TIS_OFF_RAW, 32'h0000_0000);
      rchk(TIS_OFF_RAW, 32'h0000_070f, TIS_RESP_OKAY);
      wr(TIS_OFF_CLEAR, 32'h0000_0000);
      rchk(TIS_OFF_RAW, 32'h0000_070f, TIS_RESP_OKAY);
      wr(TIS_OFF_CLEAR, 32'h0000_070f);
      rchk(TIS_OFF_RAW, 32'h0000_0000, TIS_RESP_OKAY);
      $display("test raw done");
   endtask
   task automatic t_mask();
      wr(TIS_OFF_ENABLE, 32'h0000_070f);
      rchk(TIS_OFF_ENABLE, 32'h0000_070f, TIS_RESP_OKAY);
      for (int i = 0; i < 7; i++)
      begin
         fire(i);
         rchk(TIS_OFF_MASKED, bit_of(i), TIS_RESP_OKAY);
         chk(32'(irq), 32'h0000_0001);
         wr(TIS_OFF_MASKED, 32'h0000_0000);
         rchk(TIS_OFF_MASKED, bit_of(i), TIS_RESP_OKAY);
         wr(TIS_OFF_CLEAR, bit_of(i));
         rchk(TIS_OFF_MASKED, 32'h0000_0000, TIS_RESP_OKAY);
         chk(32'(irq), 32'h0000_0000);
      end
      fire(6);
      wr(TIS_OFF_ENABLE, 32'h0000_030f);
      rchk(TIS_OFF_MASKED, 32'h0000_0000, TIS_RESP_OKAY);
      chk(32'(irq), 32'h0000_0000);
      rchk(TIS_OFF_RAW, 32'h0000_0400, TIS_RESP_OKAY);
      wr(TIS_OFF_CLEAR, 32'h0000_0400);
      $display("test mask done");
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      #2_000_000;
      num_errors++;
      report_and_stop();
   end
   initial
   begin
      repeat (8) @(posedge core_clk);
      sys_rst <= 0;
      t_reset();
      t_raw();
      t_mask();
      report_and_stop();
   end
endmodule

/* File: verification/tis_timer_irq_asserts.sv */
`timescale 1ns/1ps
module tis_timer_irq_asserts
   import tis_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic a_timeout,
   input wire logic a_capture_match,
   input wire logic a_capture_event,
   input wire logic clock_event,
   input wire logic b_timeout,
   input wire logic b_capture_match,
   input wire logic b_capture_event,
   input wire logic irq,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [TIS_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   logic any_ev;
   logic rd_bad;
   assign any_ev = a_timeout | a_capture_match | a_capture_event | clock_event | b_timeout
      | b_capture_match | b_capture_event;
   assign rd_bad = !(s_axi_araddr inside {TIS_OFF_ENABLE, TIS_OFF_RAW, TIS_OFF_MASKED,
      TIS_OFF_CLEAR});
   // ******************************
   // properties
   // ******************************
   property p_rst; $past(sys_rst) |-> !irq && !s_axi_bvalid && !s_axi_rvalid; endproperty
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   property p_bans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid; endproperty
   property p_resv; s_axi_rvalid |-> (s_axi_rdata & ~TIS_IMPL_MASK) == 32'h0000_0000;
   endproperty
   property p_slverr; s_axi_arvalid && s_axi_arready && rd_bad
      |=> s_axi_rresp == TIS_RESP_SLVERR && s_axi_rdata == 32'h0000_0000; endproperty
   property p_irq_rise; $rose(irq) |-> $past(any_ev, 2) || $past(s_axi_bvalid); endproperty
   a_rst: assert property (p_rst)
      else $error("irq or response up after reset");
   a_bhold: assert property (p_bhold)
      else $error("write response dropped early");
   a_rhold: assert property (p_rhold)
      else $error("read response dropped early");
   a_rans: assert property (p_rans)
      else $error("read not answered");
   a_bans: assert property (p_bans)
      else $error("write not answered");
   a_resv: assert property (p_resv)
      else $error("reserved bits nonzero");
   a_slverr: assert property (p_slverr)
      else $error("unmapped read not refused");
   a_irq_rise: assert property (p_irq_rise)
      else $error("irq rose without cause");
   c_irq: cover property ($rose(irq));
   c_err: cover property (s_axi_rvalid && s_axi_rresp == TIS_RESP_SLVERR);
   c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind tis_timer_irq tis_timer_irq_asserts u_chk
(
   .core_clk(core_clk),
   .sys_rst(sys_rst),
   .a_timeout(a_timeout),
   .a_capture_match(a_capture_match),
   .a_capture_event(a_capture_event),
   .clock_event(clock_event),
   .b_timeout(b_timeout),
   .b_capture_match(b_capture_match),
   .b_capture_event(b_capture_event),
   .irq(irq),
   .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready)
);
